/* File: pkg/cis_pkg.sv */
// Constants, register map and types of the current input scaling block.
package cis_pkg;

  // ==========================================================================
  // Converter and data widths
  localparam int ADC_BITS = 12;
  localparam int ADC_STEPS = 4095;
  localparam int DATA_W = 16;
  localparam int STAT_W = 8;
  localparam int FIFO_W = DATA_W + STAT_W;
  localparam int FIFO_DEPTH = 8;
  localparam int GAIN_FRAC = 8;

  // ==========================================================================
  // Register indexes; the byte address is four times the index
  localparam logic [7:0] IDX_RAW = 8'h00;
  localparam logic [7:0] IDX_STATUS = 8'h01;
  localparam logic [7:0] IDX_VCAL_OFF = 8'h11;
  localparam logic [7:0] IDX_VCAL_GAIN = 8'h12;
  localparam logic [7:0] IDX_MAKER_OFF = 8'h13;
  localparam logic [7:0] IDX_MAKER_GAIN = 8'h14;
  localparam logic [7:0] IDX_FEATURE = 8'h20;
  localparam logic [7:0] IDX_USER_OFF = 8'h21;
  localparam logic [7:0] IDX_USER_GAIN = 8'h22;

  // ==========================================================================
  // Reset values; a gain of 0x0100 is 1.0
  localparam logic [15:0] RST_RAW = 16'h0000;
  localparam logic [15:0] RST_VCAL_OFF = 16'h0000;
  localparam logic [15:0] RST_VCAL_GAIN = 16'h0801;
  localparam logic [15:0] RST_MAKER_OFF = 16'h0000;
  localparam logic [15:0] RST_MAKER_GAIN = 16'h0100;
  localparam logic [15:0] RST_MAKER_OFF_4MA = 16'hE001;
  localparam logic [15:0] RST_MAKER_GAIN_4MA = 16'h0140;
  localparam logic [15:0] RST_FEATURE = 16'h0002;
  localparam logic [15:0] RST_USER_OFF = 16'h0000;
  localparam logic [15:0] RST_USER_GAIN = 16'h0100;

  // ==========================================================================
  // Field positions
  localparam int FEAT_USER_EN = 0;
  localparam int FEAT_MAKER_EN = 1;
  localparam int FEAT_FMT_LO = 2;
  localparam int ST_OVER_RANGE = 0;
  localparam int ST_WDOG = 1;
  localparam int ST_RUN = 2;
  localparam logic [1:0] FMT_TWOS = 2'h0;
  localparam logic [1:0] FMT_SIGN_MAG = 2'h1;

  // ==========================================================================
  // Watchdog timing
  localparam int WDOG_TIME_MS = 100;
  localparam int CLK_HZ = 10_000_000;
  localparam int WDOG_CYCLES = WDOG_TIME_MS * (CLK_HZ / 1000);
  localparam int WDOG_W = 20;

  typedef enum logic {BUS_IDLE, BUS_WAIT} cis_bus_state_t;

endpackage

/* File: hw/cis_top.sv */
// Current input scaling block with its sample FIFO and AHB-Lite registers.
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps

// ============================================================================
// Sample FIFO
module cis_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic [AW:0] count_d;
  logic ready_q;
  wire push = in_valid && ready_q;
  wire pop = out_valid && out_ready;

  assign count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
  assign in_ready = ready_q;
  assign out_valid = (count_q != '0);
  assign out_data = mem[rd_ptr_q];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      ready_q <= 1'b1;
    end else begin
      wr_ptr_q <= push ? wr_ptr_q + 1'b1 : wr_ptr_q;
      rd_ptr_q <= pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
      count_q <= count_d;
      ready_q <= (count_d != FULL);
    end
  end
endmodule

// ============================================================================
// Top level
module cis_top
  import cis_pkg::*;
#(
  parameter int WDOG_LIMIT = WDOG_CYCLES
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Converter side
  input wire logic adc_valid,
  input wire logic [ADC_BITS-1:0] adc_sample,
  input wire logic adc_limit,
  input wire logic span_4ma,
  output logic adc_ready,
  // Coupler side process data
  input wire logic coupler_xfer,
  output logic pd_valid,
  input wire logic pd_ready,
  output logic [DATA_W-1:0] pd_data,
  output logic [STAT_W-1:0] pd_status,
  // Indicators
  output logic run_led,
  output logic error_led
);

  // ==========================================================================
  // Arithmetic helpers
  function automatic logic [15:0] cis_sat(input logic signed [33:0] v);
    if (v > 34'sh00007FFF) begin
      return 16'h7FFF;
    end else if (v < -34'sh00008000) begin
      return 16'h8000;
    end else begin
      return v[15:0];
    end
  endfunction

  // Straight line: offset plus gain times value, gain in 8.8 fixed point.
  function automatic logic [15:0] cis_line(input logic [15:0] off,
                                           input logic [15:0] gain,
                                           input logic [15:0] x);
    logic signed [31:0] m;
    logic signed [33:0] s;
    m = $signed(gain) * $signed(x);
    s = 34'(m >>> GAIN_FRAC) + 34'($signed(off));
    return cis_sat(s);
  endfunction

  function automatic logic [15:0] cis_fmt(input logic [1:0] fmt,
                                          input logic [15:0] v);
    logic [15:0] mag;
    mag = v[15] ? 16'(-v) : v;
    if (fmt == FMT_SIGN_MAG) begin
      return {v[15], mag[14:0]};
    end else begin
      return v;
    end
  endfunction

  // ==========================================================================
  // Registers
  logic [15:0] raw_sample_value_q;
  logic [15:0] vendor_cal_offset_q;
  logic [15:0] vendor_cal_gain_q;
  logic [15:0] maker_scale_offset_q;
  logic [15:0] maker_scale_gain_q;
  logic [15:0] feature_select_q;
  logic [15:0] user_scale_offset_q;
  logic [15:0] user_scale_gain_q;
  logic wdog_flag_q;
  logic strap_done_q;

  // ==========================================================================
  // Bus slave state
  cis_bus_state_t bus_state_q;
  logic [7:0] idx_q;
  logic write_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;

  wire take = hsel && hready && htrans[1] && (bus_state_q == BUS_IDLE);
  wire wr_now = (bus_state_q == BUS_WAIT) && write_q;
  wire [15:0] wdat = hwdata[15:0];
  wire wr_vco = wr_now && (idx_q == IDX_VCAL_OFF);
  wire wr_vcg = wr_now && (idx_q == IDX_VCAL_GAIN);
  wire wr_mko = wr_now && (idx_q == IDX_MAKER_OFF);
  wire wr_mkg = wr_now && (idx_q == IDX_MAKER_GAIN);
  wire wr_fea = wr_now && (idx_q == IDX_FEATURE);
  wire wr_uso = wr_now && (idx_q == IDX_USER_OFF);
  wire wr_usg = wr_now && (idx_q == IDX_USER_GAIN);
  wire wr_sta = wr_now && (idx_q == IDX_STATUS);

  // ==========================================================================
  // Watchdog
  logic [WDOG_W-1:0] wdog_cnt_q;
  logic run_led_q;
  logic error_led_q;
  wire wdog_expired = (wdog_cnt_q == WDOG_W'(WDOG_LIMIT - 1));

  // ==========================================================================
  // Sample processing
  wire sample_take = adc_valid && adc_ready;
  wire [15:0] raw16 = {4'h0, adc_sample};
  wire [15:0] cal_sum = cis_sat(34'($signed(vendor_cal_offset_q)) +
                                34'($signed(raw16)));
  wire [15:0] y_cal = cis_line(16'h0000, vendor_cal_gain_q, cal_sum);
  wire maker_en = feature_select_q[FEAT_MAKER_EN];
  wire user_en = feature_select_q[FEAT_USER_EN];
  wire [1:0] out_fmt = feature_select_q[FEAT_FMT_LO +: 2];
  wire [15:0] y_maker = cis_line(maker_scale_offset_q, maker_scale_gain_q,
                                 y_cal);
  wire [15:0] y_stage1 = maker_en ? y_maker : y_cal;
  wire [15:0] y_user = cis_line(user_scale_offset_q, user_scale_gain_q,
                                y_stage1);
  wire [15:0] y_out = user_en ? y_user : y_stage1;
  wire [7:0] stat_byte = {5'h00, run_led_q, wdog_flag_q, adc_limit};
  wire [FIFO_W-1:0] push_word = {stat_byte, cis_fmt(out_fmt, y_out)};

  logic f_out_valid;
  logic [FIFO_W-1:0] f_out_data;
  logic pd_valid_q;
  logic [FIFO_W-1:0] pd_word_q;
  wire pd_load = !pd_valid_q || pd_ready;
  wire f_pop = f_out_valid && pd_load;

  cis_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(hclk),
    .rst_n(hresetn),
    .in_valid(adc_valid),
    .in_ready(adc_ready),
    .in_data(push_word),
    .out_valid(f_out_valid),
    .out_ready(pd_load),
    .out_data(f_out_data)
  );

  // Output stage holds each word until the coupler takes it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pd_valid_q <= 1'b0;
      pd_word_q <= '0;
    end else if (pd_load) begin
      pd_valid_q <= f_out_valid;
      pd_word_q <= f_pop ? f_out_data : pd_word_q;
    end
  end

  assign pd_valid = pd_valid_q;
  assign pd_data = pd_word_q[DATA_W-1:0];
  assign pd_status = pd_word_q[FIFO_W-1:DATA_W];

  // ==========================================================================
  // Raw sample register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      raw_sample_value_q <= RST_RAW;
    end else if (sample_take) begin
      raw_sample_value_q <= raw16;
    end
  end

  // ==========================================================================
  // Calibration and scaling registers
  // The span strap is caught on the first clock after reset release and
  // loads the maker line that stretches 4-20 mA onto the full output range.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_done_q <= 1'b0;
      maker_scale_offset_q <= RST_MAKER_OFF;
      maker_scale_gain_q <= RST_MAKER_GAIN;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      if (span_4ma) begin
        maker_scale_offset_q <= RST_MAKER_OFF_4MA;
        maker_scale_gain_q <= RST_MAKER_GAIN_4MA;
      end
    end else begin
      if (wr_mko) begin
        maker_scale_offset_q <= wdat;
      end
      if (wr_mkg) begin
        maker_scale_gain_q <= wdat;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vendor_cal_offset_q <= RST_VCAL_OFF;
      vendor_cal_gain_q <= RST_VCAL_GAIN;
      feature_select_q <= RST_FEATURE;
      user_scale_offset_q <= RST_USER_OFF;
      user_scale_gain_q <= RST_USER_GAIN;
    end else begin
      if (wr_vco) begin
        vendor_cal_offset_q <= wdat;
      end
      if (wr_vcg) begin
        vendor_cal_gain_q <= wdat;
      end
      if (wr_fea) begin
        feature_select_q <= wdat;
      end
      if (wr_uso) begin
        user_scale_offset_q <= wdat;
      end
      if (wr_usg) begin
        user_scale_gain_q <= wdat;
      end
    end
  end

  // ==========================================================================
  // Watchdog and indicators
  // A new expiry sets the sticky flag even in the cycle it is cleared.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdog_cnt_q <= '0;
      wdog_flag_q <= 1'b0;
      run_led_q <= 1'b0;
      error_led_q <= 1'b0;
    end else begin
      if (coupler_xfer) begin
        wdog_cnt_q <= '0;
      end else if (!wdog_expired) begin
        wdog_cnt_q <= wdog_cnt_q + 1'b1;
      end
      if (wdog_expired) begin
        wdog_flag_q <= 1'b1;
      end else if (wr_sta && hwdata[ST_WDOG]) begin
        wdog_flag_q <= 1'b0;
      end
      run_led_q <= !wdog_expired;
      error_led_q <= adc_limit;
    end
  end

  assign run_led = run_led_q;
  assign error_led = error_led_q;

  // ==========================================================================
  // Read multiplexer
  logic [15:0] rd_mux;
  always_comb begin
    case (idx_q)
      IDX_RAW: rd_mux = raw_sample_value_q;
      IDX_STATUS: rd_mux = {13'h0000, run_led_q, wdog_flag_q, error_led_q};
      IDX_VCAL_OFF: rd_mux = vendor_cal_offset_q;
      IDX_VCAL_GAIN: rd_mux = vendor_cal_gain_q;
      IDX_MAKER_OFF: rd_mux = maker_scale_offset_q;
      IDX_MAKER_GAIN: rd_mux = maker_scale_gain_q;
      IDX_FEATURE: rd_mux = feature_select_q;
      IDX_USER_OFF: rd_mux = user_scale_offset_q;
      IDX_USER_GAIN: rd_mux = user_scale_gain_q;
      default: rd_mux = 16'h0000;
    endcase
  end

  // ==========================================================================
  // Bus slave: every transfer gets one wait state, then completes OKAY.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state_q <= BUS_IDLE;
      idx_q <= 8'h00;
      write_q <= 1'b0;
      hrdata_q <= 32'h00000000;
      hreadyout_q <= 1'b1;
    end else begin
      case (bus_state_q)
        BUS_IDLE: begin
          if (take) begin
            bus_state_q <= BUS_WAIT;
            idx_q <= (haddr[31:10] == '0) ? haddr[9:2] : 8'hFF;
            write_q <= hwrite;
            hreadyout_q <= 1'b0;
          end
        end
        BUS_WAIT: begin
          bus_state_q <= BUS_IDLE;
          hrdata_q <= write_q ? 32'h00000000 : {16'h0000, rd_mux};
          hreadyout_q <= 1'b1;
        end
        default: begin
          bus_state_q <= BUS_IDLE;
          hreadyout_q <= 1'b1;
        end
      endcase
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;

endmodule

/* File: verif/cis_top_asserts.sv */
// Concurrent checks on the ports of the current input scaling block.
`timescale 1ns/1ps

// ============================================================================
// Checker
module cis_top_asserts
  import cis_pkg::*;
#(
  parameter int WDOG_LIMIT = 20
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Register bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Sample stream
  input wire logic adc_valid,
  input wire logic adc_ready,
  input wire logic adc_limit,
  input wire logic coupler_xfer,
  input wire logic pd_valid,
  input wire logic pd_ready,
  input wire logic [DATA_W-1:0] pd_data,
  input wire logic [STAT_W-1:0] pd_status,
  // Indicators
  input wire logic run_led,
  input wire logic error_led
);
  logic [7:0] gap_q;
  logic [7:0] gap_d;
  wire take_w = hsel && hready && htrans[1] && hreadyout;
  wire gap_max_w = (gap_q == 8'hFF);

  // Counts the cycles since the coupler last exchanged data.
  assign gap_d = coupler_xfer ? 8'h00 : (gap_max_w ? gap_q : gap_q + 8'h01);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_q <= 8'h00;
    end else begin
      gap_q <= gap_d;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_wait;
    !hreadyout;
  endsequence
  sequence s_done;
    hreadyout;
  endsequence

  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_wait_state: assert property (take_w |=> s_wait ##1 s_done)
    else $error("wait state not one cycle");
  a_ready_back: assert property (!hreadyout |=> hreadyout)
    else $error("ready stayed low");
  a_pd_hold: assert property (
    pd_valid && !pd_ready |=> pd_valid && $stable(pd_data)
      && $stable(pd_status))
    else $error("process word changed while stalled");
  a_sample_out: assert property (
    adc_valid && adc_ready |-> ##[1:40] pd_valid)
    else $error("no process word after sample");
  a_ready_drop: assert property ($fell(adc_ready) |-> pd_valid)
    else $error("sample refused while output empty");
  a_error_follow: assert property (
    1'b1 |=> error_led == $past(adc_limit))
    else $error("error indicator not following limit");
  a_wdog_expire: assert property (gap_q >= WDOG_LIMIT |-> !run_led)
    else $error("run indicator on after exchange gap");
  a_run_restore: assert property (coupler_xfer |-> ##[1:2] run_led)
    else $error("run indicator not restored");
endmodule

bind cis_top cis_top_asserts #(.WDOG_LIMIT(WDOG_LIMIT)) i_asserts (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .adc_valid(adc_valid), .adc_ready(adc_ready), .adc_limit(adc_limit),
  .coupler_xfer(coupler_xfer), .pd_valid(pd_valid), .pd_ready(pd_ready),
  .pd_data(pd_data), .pd_status(pd_status), .run_led(run_led),
  .error_led(error_led)
);

/* File: verif/cis_coupler_model.sv */
// Behavioural bus coupler that drains process data and paces the watchdog.
`timescale 1ns/1ps

// ============================================================================
// Coupler model
module cis_coupler_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Commands from the bench
  input wire logic pulse_en,
  input wire logic stall,
  // Process data
  input wire logic pd_valid,
  input wire logic [15:0] pd_data,
  input wire logic [7:0] pd_status,
  output logic pd_ready,
  output logic coupler_xfer
);
  logic [23:0] rxq[$];
  logic [2:0] tick_q;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_q <= 3'h0;
      pd_ready <= 1'b0;
      coupler_xfer <= 1'b0;
    end else begin
      tick_q <= tick_q + 3'h1;
      coupler_xfer <= pulse_en && (tick_q == 3'h7);
      pd_ready <= !stall;
      if (pd_valid && pd_ready) begin
        rxq.push_back({pd_status, pd_data});
      end
    end
  end
endmodule

/* File: verif/current_input_scaling_bench.sv */
// Self-checking bench of the current input scaling block.
`timescale 1ns/1ps

// ============================================================================
// Bench
module current_input_scaling_bench
  import cis_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic adc_valid = 1'b0;
  logic [ADC_BITS-1:0] adc_sample = 12'h000;
  logic adc_limit = 1'b0;
  logic span_4ma = 1'b0;
  logic pulse_en = 1'b1;
  logic stall = 1'b0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hreadyout, hresp, adc_ready, coupler_xfer, pd_valid, pd_ready;
  logic run_led, error_led;
  logic [DATA_W-1:0] pd_data;
  logic [STAT_W-1:0] pd_status;
  int failures = 0;
  int checks = 0;

  always #50 hclk = ~hclk;

  cis_top #(.WDOG_LIMIT(20)) i_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .adc_valid,
    .adc_sample, .adc_limit, .span_4ma, .adc_ready, .coupler_xfer,
    .pd_valid, .pd_ready, .pd_data, .pd_status, .run_led, .error_led);
  cis_coupler_model i_cpl (.hclk, .hresetn, .pulse_en, .stall, .pd_valid,
    .pd_data, .pd_status, .pd_ready, .coupler_xfer);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic bus(input logic w, input logic [7:0] ix, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {22'h0, ix, 2'b00};
    hwrite <= w;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata;
    if (n >= 100) failures++;
  endtask

  task automatic rchk(input logic [7:0] ix, input logic [15:0] exp);
    bus(1'b0, ix, 32'h0);
    check(rd, {16'h0, exp});
  endtask

  task automatic sample(input logic [11:0] raw, input logic lim,
                        input logic [15:0] exp);
    int n0;
    int n;
    n0 = i_cpl.rxq.size();
    n = 0;
    adc_valid <= 1'b1;
    adc_sample <= raw;
    adc_limit <= lim;
    do begin
      @(posedge hclk);
      n++;
    end while (adc_ready !== 1'b1 && n < 50);
    adc_valid <= 1'b0;
    while (i_cpl.rxq.size() == n0 && n < 100) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 100) failures++;
    check({8'h0, i_cpl.rxq[$]}, {8'h00, 5'h00, 2'b10, lim, exp});
  endtask

  // Reference straight line, saturated to signed sixteen bits.
  function automatic logic [15:0] lin(input logic [15:0] b,
                                      input logic [15:0] a,
                                      input logic [15:0] x);
    longint v;
    v = $signed(b) + (($signed(a) * longint'($signed(x))) >>> 8);
    if (v > 32767) return 16'h7FFF;
    if (v < -32768) return 16'h8000;
    return v[15:0];
  endfunction

  task automatic t_regs();
    logic [7:0] ix [7] = '{IDX_VCAL_OFF, IDX_VCAL_GAIN, IDX_MAKER_OFF,
      IDX_MAKER_GAIN, IDX_FEATURE, IDX_USER_OFF, IDX_USER_GAIN};
    logic [15:0] rv [7] = '{RST_VCAL_OFF, RST_VCAL_GAIN, RST_MAKER_OFF,
      RST_MAKER_GAIN, RST_FEATURE, RST_USER_OFF, RST_USER_GAIN};
    foreach (ix[i]) rchk(ix[i], rv[i]);
    rchk(IDX_STATUS, 16'h0004);
    bus(1'b1, 8'h3F, 32'hFFFF);
    rchk(8'h3F, 16'h0000);
    bus(1'b1, IDX_RAW, 32'h0ABC);
    rchk(IDX_RAW, 16'h0000);
    bus(1'b1, IDX_USER_OFF, 32'h1234);
    rchk(IDX_USER_OFF, 16'h1234);
  endtask

  task automatic t_span();
    sample(12'hFFF, 1'b1, 16'h7FFF);
    check(error_led, 1'b1);
    rchk(IDX_RAW, 16'h0FFF);
    sample(12'h000, 1'b0, 16'h0000);
    check(error_led, 1'b0);
    sample(12'h7FF, 1'b0, 16'h3FFF);
  endtask

  task automatic t_modes();
    logic [15:0] e [4];
    e[0] = 16'd1005;
    e[1] = lin(16'hFFF0, 16'h0180, e[0]);
    e[2] = lin(16'h0010, 16'h0200, e[0]);
    e[3] = lin(16'hFFF0, 16'h0180, e[2]);
    bus(1'b1, IDX_VCAL_OFF, 32'h0005);
    bus(1'b1, IDX_VCAL_GAIN, 32'h0100);
    bus(1'b1, IDX_MAKER_OFF, 32'h0010);
    bus(1'b1, IDX_MAKER_GAIN, 32'h0200);
    bus(1'b1, IDX_USER_OFF, 32'hFFF0);
    bus(1'b1, IDX_USER_GAIN, 32'h0180);
    for (int f = 0; f < 4; f++) begin
      bus(1'b1, IDX_FEATURE, 32'(f));
      sample(12'd1000, 1'b0, e[f]);
    end
  endtask

  task automatic t_format();
    bus(1'b1, IDX_VCAL_OFF, 32'h0000);
    bus(1'b1, IDX_USER_OFF, 32'hFF00);
    bus(1'b1, IDX_USER_GAIN, 32'h0100);
    bus(1'b1, IDX_FEATURE, 32'h0001);
    sample(12'h000, 1'b0, 16'hFF00);
    bus(1'b1, IDX_FEATURE, {28'h0, FMT_SIGN_MAG, 2'b01});
    sample(12'h000, 1'b0, 16'h8100);
  endtask

  task automatic t_stream();
    int k;
    int n0;
    bus(1'b1, IDX_FEATURE, 32'h0000);
    n0 = i_cpl.rxq.size();
    stall <= 1'b1;
    adc_valid <= 1'b1;
    adc_sample <= 12'h100;
    k = 0;
    repeat (30) begin
      @(posedge hclk);
      if (adc_ready === 1'b1) begin
        k++;
        adc_sample <= 12'h100 + 12'(k);
      end
    end
    adc_valid <= 1'b0;
    stall <= 1'b0;
    check(32'(k), 32'd9);
    repeat (30) @(posedge hclk);
    check(32'(i_cpl.rxq.size() - n0), 32'd9);
    for (int i = 0; i < 9; i++) begin
      check(i_cpl.rxq[n0 + i][15:0], 16'h100 + 16'(i));
    end
  endtask

  task automatic t_wdog();
    pulse_en <= 1'b0;
    repeat (40) @(posedge hclk);
    check(run_led, 1'b0);
    rchk(IDX_STATUS, 16'h0002);
    pulse_en <= 1'b1;
    repeat (12) @(posedge hclk);
    check(run_led, 1'b1);
    bus(1'b1, IDX_STATUS, 32'h0002);
    rchk(IDX_STATUS, 16'h0004);
  endtask

  // A second reset with the strap high selects the 4-20 mA maker line.
  task automatic t_strap();
    logic [15:0] y;
    y = lin(16'h0000, RST_VCAL_GAIN, 16'd819);
    y = lin(RST_MAKER_OFF_4MA, RST_MAKER_GAIN_4MA, y);
    hresetn <= 1'b0;
    span_4ma <= 1'b1;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    check(run_led, 1'b1);
    rchk(IDX_MAKER_OFF, RST_MAKER_OFF_4MA);
    rchk(IDX_MAKER_GAIN, RST_MAKER_GAIN_4MA);
    rchk(IDX_VCAL_GAIN, RST_VCAL_GAIN);
    sample(12'hFFF, 1'b0, 16'h7FFF);
    sample(12'd819, 1'b0, y);
  endtask

  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    t_regs();
    $display("register test done");
    t_span();
    $display("span test done");
    t_modes();
    $display("scaling test done");
    t_format();
    $display("format test done");
    t_stream();
    $display("stream test done");
    t_wdog();
    $display("watchdog test done");
    t_strap();
    $display("strap test done");
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge hclk);
    failures++;
    tally_and_finish();
  end
endmodule
